// ==== design/ppss_top.sv ====
// pin ownership selection for shared peripheral pins
`timescale 1ns/1ps
`default_nettype none
module ppss_top
  import ppss_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 nrst_in,
  // straps and selects
  input  wire logic                 cell_select_strap_pin_in,
  input  wire logic                 pci_select_in,
  input  wire logic                 serial_port2_select_input_in,
  input  wire logic                 autoinit_strap_pin_in,
  // software gpio configuration for upper pins
  input  wire logic [GPIO_HI_W-1:0] gpio_pin_enable_bit_in,
  input  wire logic [GPIO_HI_W-1:0] gpio_pin_direction_bit_in,
  // owner enables
  output var  ppss_en_t             en_out,
  output logic [GPIO_HI_W-1:0]      gpio_hi_oe_out,
  output logic                      cell_standalone_oe_out,
  output logic                      sp1_standalone_oe_out,
  output logic                      pci_standalone_oe_out
);

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic       strap_done_q;
  logic       cell_sel_q;
  logic       pci_sel_q;
  logic       sp2_sel_rst_q;
  logic       autoinit_q;
  logic       sp2_sel_q;
  logic [1:0] gap_q;
  ppss_state_t state_q;
  ppss_state_t state_d;
  ppss_en_t    en_d;

  // straps taken on the first edge after reset release
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_done_q  <= 1'b0;
      cell_sel_q    <= STRAP_RST[0];
      pci_sel_q     <= STRAP_RST[0];
      sp2_sel_rst_q <= STRAP_RST[0];
      autoinit_q    <= STRAP_RST[0];
    end else if (!strap_done_q) begin
      strap_done_q  <= 1'b1;
      cell_sel_q    <= cell_select_strap_pin_in;
      pci_sel_q     <= pci_select_in;
      sp2_sel_rst_q <= serial_port2_select_input_in;
      autoinit_q    <= autoinit_strap_pin_in;
    end
  end

  // ****************************************************************
  // serial port 2 / prom ownership
  // ****************************************************************
  wire prom_req = pci_sel_q & ~sp2_sel_q;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sp2_sel_q <= 1'b1;
    end else if (!strap_done_q) begin
      sp2_sel_q <= serial_port2_select_input_in;
    end else begin
      sp2_sel_q <= serial_port2_select_input_in;
    end
  end

  // two dead cycles between owners
  always_comb begin
    state_d = state_q;
    case (state_q)
      PPSS_SP2:  if (prom_req) state_d = PPSS_GAP;
      PPSS_GAP:  if (gap_q == GAP_CYCLES)
                   state_d = prom_req ? PPSS_PROM : PPSS_SP2;
      PPSS_PROM: if (!prom_req) state_d = PPSS_GAP;
      default:   state_d = PPSS_SP2;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= PPSS_GAP;
      gap_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      gap_q   <= (state_q == PPSS_GAP && strap_done_q) ?
                 gap_q + 2'h1 : 2'h0;
    end
  end

  // ****************************************************************
  // enables
  // ****************************************************************
  wire ready = strap_done_q;
  always_comb begin
    en_d.host_en     = ready & ~pci_sel_q;
    en_d.pci_en      = ready & pci_sel_q;
    en_d.sp2_en      = ready & (state_q == PPSS_SP2);
    en_d.prom_en     = ready & (state_q == PPSS_PROM);
    en_d.sp1_en      = ready & ~cell_sel_q;
    en_d.cell_en     = ready & cell_sel_q;
    en_d.always_en   = 1'b1;
    en_d.autoinit_go = ready & pci_sel_q & ~sp2_sel_rst_q
                       & autoinit_q;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_out                 <= '0;
      gpio_hi_oe_out         <= '0;
      cell_standalone_oe_out <= 1'b0;
      sp1_standalone_oe_out  <= 1'b0;
      pci_standalone_oe_out  <= 1'b0;
    end else begin
      en_out                 <= en_d;
      gpio_hi_oe_out         <= {GPIO_HI_W{en_d.host_en}} &
                                gpio_pin_enable_bit_in &
                                gpio_pin_direction_bit_in;
      cell_standalone_oe_out <= en_d.cell_en;
      sp1_standalone_oe_out  <= en_d.sp1_en;
      pci_standalone_oe_out  <= en_d.pci_en;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // port 2 and prom both released
  sequence s_both_off;
    !en_out.sp2_en && !en_out.prom_en;
  endsequence

  sequence s_dead_time;
    s_both_off ##1 s_both_off;
  endsequence

  // ownership and always-on groups
  a_owner_excl: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !(en_out.sp2_en && en_out.prom_en) && !(en_out.host_en && en_out.pci_en)
    && !(en_out.sp1_en && en_out.cell_en))
    else $error("two owners on shared pins");
  a_always_on: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    strap_done_q |=> en_out.always_en)
    else $error("always-on group dropped");

  // cell port, serial port 1 and straps held after sampling
  a_cell_sel: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    $rose(strap_done_q) |=> en_out.cell_en == cell_sel_q)
    else $error("cell select not taken");
  a_sp1_mode: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && !cell_sel_q) |=> en_out.sp1_en && !cell_standalone_oe_out)
    else $error("port 1 mode wrong");
  a_cell_mode: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && cell_sel_q) |=> en_out.cell_en && !sp1_standalone_oe_out)
    else $error("cell mode wrong");
  a_straps_held: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (strap_done_q && $past(strap_done_q)) |-> $stable(cell_sel_q)
    && $stable(pci_sel_q) && $stable(sp2_sel_rst_q) && $stable(autoinit_q))
    else $error("strap changed after sampling");

  // host port, pci and upper gpio
  a_host_mode: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && !pci_sel_q) |=> en_out.host_en && !pci_standalone_oe_out)
    else $error("host mode wrong");
  a_gpio_cfg: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && !pci_sel_q) |=> gpio_hi_oe_out ==
    $past(gpio_pin_enable_bit_in & gpio_pin_direction_bit_in))
    else $error("upper gpio drive wrong");
  a_pci_mode: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && pci_sel_q) |=> en_out.pci_en && !en_out.host_en
    && gpio_hi_oe_out == '0)
    else $error("pci mode wrong");
  a_pci_pins: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && pci_sel_q) |=> pci_standalone_oe_out)
    else $error("pci standalone pins idle");

  // prom, autoinit and port 2 select
  a_prom_gate: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !pci_sel_q |=> !en_out.prom_en && !en_out.autoinit_go)
    else $error("prom owner without pci");
  a_autoinit: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    en_out.autoinit_go |-> pci_sel_q && autoinit_q)
    else $error("autoinit without straps");
  a_autoinit_on: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && pci_sel_q && !sp2_sel_rst_q && autoinit_q)
    |=> en_out.autoinit_go)
    else $error("autoinit not started");
  a_sp2_back: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    (ready && $fell(prom_req)) |-> ##[1:4] en_out.sp2_en)
    else $error("port 2 not restored");
  a_sel_track: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    strap_done_q |=> sp2_sel_q == $past(serial_port2_select_input_in))
    else $error("port 2 select not followed");

  // dead time at every port 2 handover
  a_gap_into: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    $fell(en_out.sp2_en) |-> s_dead_time)
    else $error("no dead time before prom");
  a_gap_back: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    $fell(en_out.prom_en) |-> s_dead_time)
    else $error("no dead time before port 2");

endmodule : ppss_top
`default_nettype wire

// ==== design/ppss_pkg.sv ====
// package for the peripheral pin share select block
// ****************************************************************
// ****************************************************************
package ppss_pkg;

  localparam int  GPIO_HI_W   = 7;
  localparam int  GPIO_LO_W   = 9;
  localparam logic [1:0] STRAP_RST = 2'h0;
  localparam logic [1:0] GAP_CYCLES = 2'h1;

  typedef struct packed {
    logic host_en;
    logic pci_en;
    logic prom_en;
    logic sp2_en;
    logic sp1_en;
    logic cell_en;
    logic always_en;
    logic autoinit_go;
  } ppss_en_t;

  typedef enum logic [1:0] {
    PPSS_SP2  = 2'b00,
    PPSS_GAP  = 2'b01,
    PPSS_PROM = 2'b10
  } ppss_state_t;

endpackage : ppss_pkg

// ==== verification/ppss_board.sv ====
// board straps and select drivers in front of the pin share block
`timescale 1ns/1ps
`default_nettype none
module ppss_board (
  // bench side
  input  wire logic       nrst_in,
  input  wire logic [3:0] want_in,
  // straps {cell, pci, port 2 select, autoinit}
  output logic [3:0]      strap_out
);
  logic pci_q;
  // pci select is only allowed to move while the device is in reset
  always_latch if (!nrst_in) pci_q <= want_in[2];
  assign strap_out = {want_in[3], pci_q, want_in[1:0]};
endmodule : ppss_board
`default_nettype wire

// ==== verification/test_peripheral_pin_share_select.sv ====
// self-checking bench for the pin share select block
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_pin_share_select;
  import ppss_pkg::*;
  logic                 clock_in;
  logic                 nrst_in;
  logic [3:0]           want;
  logic [3:0]           strap;
  logic [3:0]           boot_w;
  logic [GPIO_HI_W-1:0] gen;
  logic [GPIO_HI_W-1:0] gdir;
  logic [GPIO_HI_W-1:0] goe;
  ppss_en_t             en;
  logic                 c_oe;
  logic                 s1_oe;
  logic                 p_oe;
  wire logic [17:0]     seen;
  int                   miscompares = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  assign seen = {en, goe, c_oe, s1_oe, p_oe};
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  ppss_board ppss_board_inst (.nrst_in(nrst_in), .want_in(want),
    .strap_out(strap));
  ppss_top ppss_top_inst (.clock_in(clock_in), .nrst_in(nrst_in),
    .cell_select_strap_pin_in(strap[3]), .pci_select_in(strap[2]),
    .serial_port2_select_input_in(strap[1]),
    .autoinit_strap_pin_in(strap[0]), .gpio_pin_enable_bit_in(gen),
    .gpio_pin_direction_bit_in(gdir), .en_out(en), .gpio_hi_oe_out(goe),
    .cell_standalone_oe_out(c_oe), .sp1_standalone_oe_out(s1_oe),
    .pci_standalone_oe_out(p_oe));
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cycles
  task automatic boot(input logic [3:0] w);
    nrst_in = 1'b0;
    want = w;
    boot_w = w;
    cycles(5);
    check(seen, 18'h0);
    nrst_in = 1'b1;
    cycles(8);
  endtask : boot
  // expected owners and enables for straps {cell, pci, sel2, autoinit}
  function automatic logic [17:0] expect_of(input logic [3:0] w);
    logic pr;
    logic ai;
    pr = w[2] & ~w[1];
    // autoinit follows the straps as they stood at reset
    ai = boot_w[2] & ~boot_w[1] & boot_w[0];
    return {~w[2], w[2], pr, ~pr, ~w[3], w[3], 1'b1, ai,
            w[2] ? 7'h00 : gen & gdir, w[3], ~w[3], w[2]};
  endfunction : expect_of
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      final_report();
    end
  end
  // port 2 and prom never own the pins together
  always @(negedge clock_in)
    if (nrst_in === 1'b1 && en.sp2_en === 1'b1)
      check({17'h0, en.prom_en}, 18'h0);
  initial begin
    nrst_in = 1'b0;
    want = 4'h0;
    gen = 7'h55;
    gdir = 7'h33;
    cycles(5);
    for (int i = 0; i < 16; i++) begin
      boot(4'(i));
      check(seen, expect_of(want));
    end
    $display("test strap combinations done");
    boot(4'h6);
    want = 4'hc;
    gen = 7'h7f;
    cycles(10);
    check(seen, expect_of(4'h4));
    want = 4'h6;
    cycles(10);
    check(seen, expect_of(4'h6));
    $display("test run-time port 2 switch done");
    boot(4'h5);
    check(seen, expect_of(4'h5));
    want = 4'hf;
    cycles(10);
    check(seen, expect_of(4'h7));
    $display("test autoinit start done");
    final_report();
  end
endmodule : test_peripheral_pin_share_select
`default_nettype wire
